/* spcfg_defines.vh */
// Offsets, field layouts, masks and reset values of the port tuning registers
`ifndef SPCFG_DEFINES_VH
`define SPCFG_DEFINES_VH

// Register byte offsets
`define SPCFG_OFS_TL_TUNE        8'h8C
`define SPCFG_OFS_PHY_LANE       8'h90
`define SPCFG_OFS_PHY_MARGIN     8'h94
`define SPCFG_OFS_OP_MODE        8'h98

// Transaction-layer tuning word
`define SPCFG_TL_RST             32'h00791894
`define SPCFG_TL_IMPL            32'hBFFF1FFF
`define SPCFG_TL_UPOWN           32'h3C0010EF
`define SPCFG_TL_CFGWR           32'h00000060
`define SPCFG_TL_MW_BYP_BIT      5
`define SPCFG_TL_RELAX_OFF_BIT   6
`define SPCFG_TL_RATE_CNT_LO     8
`define SPCFG_TL_RATE_CNT_HI     9
`define SPCFG_TL_PORT_DIS_BIT    10
`define SPCFG_TL_RST_SEL_BIT     11
`define SPCFG_TL_PHYCTL_LO       16
`define SPCFG_TL_PHYCTL_HI       23
`define SPCFG_TL_RETRAIN_OFF_BIT 16

// PHY lane mode and delta word
`define SPCFG_PL_RST             32'h00008000
`define SPCFG_PL_IMPL            32'hFFFF807F
`define SPCFG_PL_UPOWN           32'hFFFF8000
`define SPCFG_PL_LANE_HI         6
`define SPCFG_PL_DELTA_LO        15
`define SPCFG_PL_DELTA_HI        31

// PHY transmit margin word, upstream owned
`define SPCFG_PM_RST             32'h0000116B
`define SPCFG_PM_IMPL            32'h0000FFFF
`define SPCFG_PM_UPOWN           32'h0000FFFF

// Operating mode and clock buffer word
`define SPCFG_OM_RST             32'h007F00A2
`define SPCFG_OM_IMPL            32'h0FFFFFFF
`define SPCFG_OM_UPOWN           32'h00FF0000
`define SPCFG_OM_MODE_HI         15
`define SPCFG_OM_CLKEN_LO        16
`define SPCFG_OM_CLKEN_HI        22
`define SPCFG_OM_CLKPD_BIT       23
`define SPCFG_OM_CLKEN_SIX       7'h7F
`define SPCFG_OM_CLKEN_FIVE      7'h5F

// Strap capture: edges after reset release before the synchronised straps are valid
`define SPCFG_STRAP_WAIT         2'h2

`endif

/* spcfg_sync.v */
// Two-stage synchroniser for strap and sense pins
`timescale 1ns/10ps
module spcfg_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         nrst,
  // Asynchronous level in, synchronised level out
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_r;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

/* spcfg_regs.v */
// Per-port transaction, PHY and operating-mode tuning register group
// Summary of operation
// R1 - Sideband or EEPROM loads replace the reset value of every configurable field.
// R2 - Upstream-owned fields follow the upstream copy; downstream ports cannot set them.
// R3 - Bit 6 writable, resets zero, EEPROM loadable; one turns relaxed ordering off.
// R4 - Bit 5 writable memory-write bypass disable, resets zero, sideband or EEPROM loadable.
// R5 - Bit 10 one disables the port; resets zero; changed only by sideband or EEPROM.
// R6 - Bit 11 reset selection, meaningful on upstream port only, resets to one.
// R7 - Bits 9:8 give rate change attempt count; reset to zero.
// R8 - Bits 23:16 mirror PHY control byte, reset 79h; bit 16 disables error retrain.
// R9 - Clock buffer bit 23 resets from the sampled power-down strap pin.
// R10 - Reference clock outputs run while bit 23 is zero, all stop when one.
// R11 - Bits 22:16 enable clock pairs 7..1; reset 7Fh six-port, 5Fh five-port.
// R12 - Bits 15:0 read-only mode indications, reset 00A2h, with documented bit meanings.
// R13 - Lane mode bits 6:0 reset 00h; delta bits 31:15 reset 0_0001h, upstream owned.
// R14 - Reserved bits read zero; software writes to read-only bits are ignored.
// R15 - All reset values apply at fundamental reset before any load updates fields; bits 23:16 take theirs at the strap take, over any earlier load.
`timescale 1ns/10ps
`include "spcfg_defines.vh"
module spcfg_regs (
  // Clock and fundamental reset
  input  wire        clk,
  input  wire        nrst,
  // Strap and role pins
  input  wire        clock_buffer_powerdown_strap,
  input  wire        six_port_package,
  input  wire        upstream_role,
  // Configuration software access
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_addr,
  input  wire [31:0] cfg_wdata,
  input  wire [3:0]  cfg_be,
  output reg  [31:0] cfg_rdata_r,
  output reg         cfg_rvalid_r,
  // Sideband (SMBus or I2C) and EEPROM autoload write ports
  input  wire        sb_wr,
  input  wire [7:0]  sb_addr,
  input  wire [31:0] sb_wdata,
  input  wire [3:0]  sb_be,
  input  wire        ee_wr,
  input  wire [7:0]  ee_addr,
  input  wire [31:0] ee_wdata,
  input  wire [3:0]  ee_be,
  // Upstream port copy of the group
  input  wire [31:0] up_tl_word,
  input  wire [31:0] up_pl_word,
  input  wire [31:0] up_pm_word,
  input  wire [31:0] up_om_word,
  // Effective field outputs
  output reg  [31:0] tl_word_r,
  output reg  [31:0] pl_word_r,
  output reg  [31:0] pm_word_r,
  output reg  [31:0] om_word_r,
  output reg         mw_bypass_off_r,
  output reg         relaxed_order_off_r,
  output reg  [1:0]  rate_change_attempt_count_r,
  output reg         port_disabled_r,
  output reg         reset_select_r,
  output reg  [7:0]  phy_control_byte_r,
  output reg         retrain_on_error_off_r,
  output reg  [6:0]  lane_mode_r,
  output reg  [16:0] phy_delta_r,
  output reg  [15:0] operating_mode_r,
  output reg  [7:1]  reference_clock_output_pair_en_r
);

  // Local copies of the four words
  reg  [31:0] tl_r;
  reg  [31:0] pl_r;
  reg  [31:0] pm_r;
  reg  [31:0] om_r;
  reg  [31:0] tl_nxt;
  reg  [31:0] pl_nxt;
  reg  [31:0] pm_nxt;
  reg  [31:0] om_nxt;
  reg  [1:0]  strap_cnt_r;
  reg         strap_done_r;
  reg  [31:0] rd_nxt;
  wire [2:0]  pins_s;
  wire        strap_pd_s;
  wire        six_port_s;
  wire        is_up_s;
  wire        strap_take;
  wire [31:0] tl_eff;
  wire [31:0] pl_eff;
  wire [31:0] pm_eff;
  wire [31:0] om_eff;

  // Word defaults, sliced for the per-field reset values
  localparam [31:0] TL_RST = `SPCFG_TL_RST;
  localparam [31:0] PL_RST = `SPCFG_PL_RST;
  localparam [31:0] OM_RST = `SPCFG_OM_RST;

  // Byte-enable merge of new data into the given bit mask
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  be;
    input [31:0] mask;
    reg   [31:0] m;
    begin
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      be_merge = (old & ~m) | (data & m);
    end
  endfunction

  // Upstream-owned bits taken from the upstream copy on a downstream port
  function [31:0] own_merge;
    input [31:0] loc;
    input [31:0] up;
    input [31:0] mask;
    input        is_up;
    begin
      if (is_up)
        own_merge = loc;
      else
        own_merge = (loc & ~mask) | (up & mask);
    end
  endfunction

  // Straps and role are pins, so they are synchronised first
  spcfg_sync #(
    .W (3)
  ) u_pins (
    .clk  (clk),
    .nrst (nrst),
    .din  ({clock_buffer_powerdown_strap, six_port_package, upstream_role}),
    .dout (pins_s)
  );

  assign strap_pd_s = pins_s[2];
  assign six_port_s = pins_s[1];
  assign is_up_s    = pins_s[0];

  // Straps are caught once, after the synchroniser has filled
  assign strap_take = !strap_done_r && (strap_cnt_r == `SPCFG_STRAP_WAIT);

  // The count freezes after the take, so straps are read once per reset
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
    end
    else
    begin
      if (!strap_done_r)
        strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_take)
        strap_done_r <= 1'b1;
    end
  end

  // Next-value logic; later writes in this process take priority
  always @*
  begin
    tl_nxt = tl_r;
    pl_nxt = pl_r;
    pm_nxt = pm_r;
    om_nxt = om_r;
    // Lowest priority, so a load of this byte in the same cycle wins
    if (strap_take)
    begin
      om_nxt[`SPCFG_OM_CLKPD_BIT] = strap_pd_s; // R9
      om_nxt[`SPCFG_OM_CLKEN_HI:`SPCFG_OM_CLKEN_LO] =
        six_port_s ? `SPCFG_OM_CLKEN_SIX : `SPCFG_OM_CLKEN_FIVE; // R11
    end
    // Software reaches only bits 6 and 5; everything else is read-only
    if (cfg_wr && cfg_addr == `SPCFG_OFS_TL_TUNE)
      tl_nxt = be_merge(tl_nxt, cfg_wdata, cfg_be, `SPCFG_TL_CFGWR); // R3 R4 R14
    // EEPROM autoload first, sideband second, so a live sideband write wins
    if (ee_wr)
    begin
      case (ee_addr)
        `SPCFG_OFS_TL_TUNE:    tl_nxt = be_merge(tl_nxt, ee_wdata, ee_be, `SPCFG_TL_IMPL); // R1
        `SPCFG_OFS_PHY_LANE:   pl_nxt = be_merge(pl_nxt, ee_wdata, ee_be, `SPCFG_PL_IMPL); // R1
        `SPCFG_OFS_PHY_MARGIN: pm_nxt = be_merge(pm_nxt, ee_wdata, ee_be, `SPCFG_PM_IMPL); // R1
        `SPCFG_OFS_OP_MODE:    om_nxt = be_merge(om_nxt, ee_wdata, ee_be, `SPCFG_OM_IMPL); // R1
        default:               tl_nxt = tl_nxt;
      endcase
    end
    // Bit 6 is only EEPROM loadable, so the sideband mask leaves it out
    if (sb_wr)
    begin
      case (sb_addr)
        `SPCFG_OFS_TL_TUNE:
          tl_nxt = be_merge(tl_nxt, sb_wdata, sb_be,
                            `SPCFG_TL_IMPL & ~(32'h1 << `SPCFG_TL_RELAX_OFF_BIT)); // R1 R3 R5
        `SPCFG_OFS_PHY_LANE:   pl_nxt = be_merge(pl_nxt, sb_wdata, sb_be, `SPCFG_PL_IMPL); // R1
        `SPCFG_OFS_PHY_MARGIN: pm_nxt = be_merge(pm_nxt, sb_wdata, sb_be, `SPCFG_PM_IMPL); // R1
        `SPCFG_OFS_OP_MODE:    om_nxt = be_merge(om_nxt, sb_wdata, sb_be, `SPCFG_OM_IMPL); // R1
        default:               tl_nxt = tl_nxt;
      endcase
    end
  end

  // Fundamental reset loads every documented default but bits 23:16, which load 7Fh; the strapped values follow at the take
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tl_r <= `SPCFG_TL_RST; // R15 R6 R7 R8
      pl_r <= `SPCFG_PL_RST; // R15 R13
      pm_r <= `SPCFG_PM_RST; // R15
      om_r <= `SPCFG_OM_RST; // R15 R12
    end
    else
    begin
      tl_r <= tl_nxt;
      pl_r <= pl_nxt;
      pm_r <= pm_nxt;
      om_r <= om_nxt;
    end
  end

  // Effective values: reserved bits forced to zero, owned bits from upstream on a downstream port
  assign tl_eff = own_merge(tl_r, up_tl_word, `SPCFG_TL_UPOWN, is_up_s) & `SPCFG_TL_IMPL; // R2 R14
  assign pl_eff = own_merge(pl_r, up_pl_word, `SPCFG_PL_UPOWN, is_up_s) & `SPCFG_PL_IMPL; // R2 R13
  assign pm_eff = own_merge(pm_r, up_pm_word, `SPCFG_PM_UPOWN, is_up_s) & `SPCFG_PM_IMPL; // R2
  assign om_eff = own_merge(om_r, up_om_word, `SPCFG_OM_UPOWN, is_up_s) & `SPCFG_OM_IMPL; // R2 R14

  // Read mux; unmapped offsets return zero
  always @*
  begin
    case (cfg_addr)
      `SPCFG_OFS_TL_TUNE:    rd_nxt = tl_eff;
      `SPCFG_OFS_PHY_LANE:   rd_nxt = pl_eff;
      `SPCFG_OFS_PHY_MARGIN: rd_nxt = pm_eff;
      `SPCFG_OFS_OP_MODE:    rd_nxt = om_eff;
      default:               rd_nxt = 32'h00000000;
    endcase
  end

  // Answer one cycle after the request; data holds until the next read
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_rdata_r  <= 32'h00000000;
      cfg_rvalid_r <= 1'b0;
    end
    else
    begin
      cfg_rvalid_r <= cfg_rd;
      if (cfg_rd)
        cfg_rdata_r <= rd_nxt; // R14
    end
  end

  // Field outputs, registered one cycle behind the effective words
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tl_word_r                        <= `SPCFG_TL_RST;
      pl_word_r                        <= `SPCFG_PL_RST;
      pm_word_r                        <= `SPCFG_PM_RST;
      om_word_r                        <= `SPCFG_OM_RST;
      // Field resets other than the clock enables are slices of the word defaults, so the two cannot drift
      mw_bypass_off_r                  <= TL_RST[`SPCFG_TL_MW_BYP_BIT];
      relaxed_order_off_r              <= TL_RST[`SPCFG_TL_RELAX_OFF_BIT];
      rate_change_attempt_count_r      <= TL_RST[`SPCFG_TL_RATE_CNT_HI:`SPCFG_TL_RATE_CNT_LO];
      port_disabled_r                  <= TL_RST[`SPCFG_TL_PORT_DIS_BIT];
      reset_select_r                   <= TL_RST[`SPCFG_TL_RST_SEL_BIT];
      phy_control_byte_r               <= TL_RST[`SPCFG_TL_PHYCTL_HI:`SPCFG_TL_PHYCTL_LO];
      retrain_on_error_off_r           <= TL_RST[`SPCFG_TL_RETRAIN_OFF_BIT];
      lane_mode_r                      <= PL_RST[`SPCFG_PL_LANE_HI:0];
      phy_delta_r                      <= PL_RST[`SPCFG_PL_DELTA_HI:`SPCFG_PL_DELTA_LO];
      operating_mode_r                 <= OM_RST[`SPCFG_OM_MODE_HI:0];
      reference_clock_output_pair_en_r <= 7'h00;
    end
    else
    begin
      tl_word_r                   <= tl_eff;
      pl_word_r                   <= pl_eff;
      pm_word_r                   <= pm_eff;
      om_word_r                   <= om_eff;
      mw_bypass_off_r             <= tl_eff[`SPCFG_TL_MW_BYP_BIT]; // R4
      relaxed_order_off_r         <= tl_eff[`SPCFG_TL_RELAX_OFF_BIT]; // R3
      rate_change_attempt_count_r <=
        tl_eff[`SPCFG_TL_RATE_CNT_HI:`SPCFG_TL_RATE_CNT_LO]; // R7
      port_disabled_r             <= tl_eff[`SPCFG_TL_PORT_DIS_BIT]; // R5
      // Reset selection has no meaning on a downstream port
      reset_select_r              <= is_up_s & tl_eff[`SPCFG_TL_RST_SEL_BIT]; // R6
      phy_control_byte_r          <= tl_eff[`SPCFG_TL_PHYCTL_HI:`SPCFG_TL_PHYCTL_LO]; // R8
      retrain_on_error_off_r      <= tl_eff[`SPCFG_TL_RETRAIN_OFF_BIT]; // R8
      lane_mode_r                 <= pl_eff[`SPCFG_PL_LANE_HI:0]; // R13
      phy_delta_r                 <= pl_eff[`SPCFG_PL_DELTA_HI:`SPCFG_PL_DELTA_LO]; // R13
      operating_mode_r            <= om_eff[`SPCFG_OM_MODE_HI:0]; // R12
      // Clocks held off until the straps are known, so no glitchy start
      if (!strap_done_r || om_eff[`SPCFG_OM_CLKPD_BIT])
        reference_clock_output_pair_en_r <= 7'h00; // R10
      else
        reference_clock_output_pair_en_r <=
          om_eff[`SPCFG_OM_CLKEN_HI:`SPCFG_OM_CLKEN_LO]; // R10 R11
    end
  end

endmodule

/* spcfg_regs_checker.sv */
// Port-level assertions for the port tuning register group
`timescale 1ns/10ps
module spcfg_regs_checker (
  // Clock, reset and pins
  input wire        clk,
  input wire        nrst,
  input wire        clock_buffer_powerdown_strap,
  input wire        upstream_role,
  // Requests
  input wire        cfg_rd,
  input wire        cfg_wr,
  input wire [7:0]  cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire [3:0]  cfg_be,
  input wire        ee_wr,
  input wire        sb_wr,
  input wire [7:0]  sb_addr,
  input wire [31:0] sb_wdata,
  input wire [3:0]  sb_be,
  // Outputs watched
  input wire [31:0] cfg_rdata_r,
  input wire        cfg_rvalid_r,
  input wire [31:0] tl_word_r,
  input wire [31:0] om_word_r,
  input wire        port_disabled_r,
  input wire        relaxed_order_off_r,
  input wire        reset_select_r,
  input wire [7:0]  phy_control_byte_r,
  input wire        retrain_on_error_off_r,
  input wire [6:0]  lane_mode_r,
  input wire [16:0] phy_delta_r,
  input wire [15:0] operating_mode_r,
  input wire [7:1]  reference_clock_output_pair_en_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Owned fields are only local once the role has been upstream for a while
  AST_RST_VALS: assert property ($rose(nrst) |-> reset_select_r
    && lane_mode_r == 7'h00 && phy_delta_r == 17'h00001
    && operating_mode_r == 16'h00A2 && phy_control_byte_r == 8'h79)
    else $error("reset values wrong after release");
  AST_PD_STRAP: assert property ($rose(nrst) && upstream_role |-> ##5
    om_word_r[23] == $past(clock_buffer_powerdown_strap, 5)) else $error("strap not captured");
  AST_RETRAIN: assert property (retrain_on_error_off_r == tl_word_r[16]
    && phy_control_byte_r == tl_word_r[23:16])
    else $error("retrain disable not tied to control byte");
  AST_SB_PORT_DIS: assert property (sb_wr && sb_addr == 8'h8C && sb_be[1] |-> ##2
    port_disabled_r == $past(sb_wdata[10], 2)) else $error("port disable not loaded");
  AST_CFG_RELAX: assert property (cfg_wr && cfg_addr == 8'h8C && cfg_be[0] && !ee_wr
    && upstream_role && $past(upstream_role, 4) |-> ##2
    relaxed_order_off_r == $past(cfg_wdata[6], 2))
    else $error("ordering bit not written");
  AST_CLK_STOP: assert property (sb_wr && sb_addr == 8'h98 && sb_be[2] && sb_wdata[23]
    && upstream_role && $past(upstream_role, 4) |-> ##2 reference_clock_output_pair_en_r == 7'h00)
    else $error("clock outputs not stopped");
  AST_CLK_EN: assert property (sb_wr && sb_addr == 8'h98 && sb_be[2] && !sb_wdata[23]
    && upstream_role && $past(upstream_role, 4) |-> ##2
    reference_clock_output_pair_en_r == $past(sb_wdata[22:16], 2))
    else $error("clock enables wrong");
  AST_RSV_ZERO: assert property (cfg_rd && cfg_addr == 8'h8C |=> cfg_rvalid_r
    && cfg_rdata_r[15:13] == 3'h0 && !cfg_rdata_r[30]) else $error("reserved bits not zero");
  AST_UNMAPPED: assert property (cfg_rd
    && !(cfg_addr inside {8'h8C, 8'h90, 8'h94, 8'h98}) |=>
    cfg_rvalid_r && cfg_rdata_r == 32'h00000000) else $error("unmapped read not zero");
endmodule

/* testbench.sv */
// Self-checking bench for the port tuning register group
`timescale 1ns/10ps
`include "spcfg_defines.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
  reg         clk = 1'b0, nrst = 1'b0, clock_buffer_powerdown_strap = 1'b0;
  reg         six_port_package = 1'b0, upstream_role = 1'b1, v;
  reg         cfg_rd = 1'b0, cfg_wr = 1'b0, sb_wr = 1'b0, ee_wr = 1'b0;
  reg  [7:0]  cfg_addr = 8'h8C, sb_addr = 8'h8C, ee_addr = 8'h8C;
  reg  [31:0] cfg_wdata = 32'h0, sb_wdata = 32'h0, ee_wdata = 32'h0, r, rexp;
  reg  [3:0]  cfg_be = 4'h0, sb_be = 4'h0, ee_be = 4'h0;
  reg  [31:0] m [0:3], own [0:3], imp [0:3], upw [0:3];
  wire [31:0] up_tl_word = upw[0], up_pl_word = upw[1], up_pm_word = upw[2], up_om_word = upw[3];
  wire [31:0] cfg_rdata_r, tl_word_r, pl_word_r, pm_word_r, om_word_r;
  wire        cfg_rvalid_r, mw_bypass_off_r, relaxed_order_off_r, port_disabled_r;
  wire        reset_select_r, retrain_on_error_off_r;
  wire [1:0]  rate_change_attempt_count_r;
  wire [7:0]  phy_control_byte_r;
  wire [6:0]  lane_mode_r;
  wire [16:0] phy_delta_r;
  wire [15:0] operating_mode_r;
  wire [7:1]  reference_clock_output_pair_en_r;
  reg  [15:0] lf = 16'h4CE8;
  integer     fail_count = 0, compares = 0, cyc = 0;
  spcfg_regs spcfg_regs_inst (
    .clk (clk), .nrst (nrst), .six_port_package (six_port_package),
    .clock_buffer_powerdown_strap (clock_buffer_powerdown_strap), .upstream_role (upstream_role),
    .cfg_rd (cfg_rd), .cfg_wr (cfg_wr), .cfg_addr (cfg_addr), .cfg_wdata (cfg_wdata),
    .cfg_be (cfg_be), .cfg_rdata_r (cfg_rdata_r), .cfg_rvalid_r (cfg_rvalid_r),
    .sb_wr (sb_wr), .sb_addr (sb_addr), .sb_wdata (sb_wdata), .sb_be (sb_be),
    .ee_wr (ee_wr), .ee_addr (ee_addr), .ee_wdata (ee_wdata), .ee_be (ee_be),
    .up_tl_word (up_tl_word), .up_pl_word (up_pl_word), .up_pm_word (up_pm_word),
    .up_om_word (up_om_word), .tl_word_r (tl_word_r), .pl_word_r (pl_word_r),
    .pm_word_r (pm_word_r), .om_word_r (om_word_r), .mw_bypass_off_r (mw_bypass_off_r),
    .relaxed_order_off_r (relaxed_order_off_r), .port_disabled_r (port_disabled_r),
    .rate_change_attempt_count_r (rate_change_attempt_count_r), .reset_select_r (reset_select_r),
    .phy_control_byte_r (phy_control_byte_r), .retrain_on_error_off_r (retrain_on_error_off_r),
    .lane_mode_r (lane_mode_r), .phy_delta_r (phy_delta_r), .operating_mode_r (operating_mode_r),
    .reference_clock_output_pair_en_r (reference_clock_output_pair_en_r)
  );
  always #25 clk = ~clk;
  function logic [31:0] rnd();
    logic [31:0] q;
    for (int k = 0; k < 32; k++)
    begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      q = {q[30:0], lf[0]};
    end
    return q;
  endfunction
  // Downstream ports show the upstream copy in owned bits
  function logic [31:0] eff(input integer i);
    return imp[i] & (upstream_role ? m[i] : (m[i] & ~own[i]) | (upw[i] & own[i]));
  endfunction
  // Kind 0 config, 1 autoload, 2 sideband
  task wr(input [7:0] a, input [31:0] d, input [3:0] be, input integer kind);
    logic [31:0] bm;
    integer i;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & imp[(a - 8'h8C) >> 2];
    i = (a - 8'h8C) >> 2;
    if (kind == 0)
      bm = (i == 0) ? bm & 32'h60 : 32'h0;
    if (kind == 2 && i == 0)
      bm = bm & ~32'h40;
    if (a <= 8'h98)
      m[i] = (m[i] & ~bm) | (d & bm);
  endtask
  task check();
    logic [31:0] t, p, o;
    t = eff(0);
    p = eff(1);
    o = eff(3);
    `CHK({tl_word_r, pl_word_r, pm_word_r, om_word_r}, {t, p, eff(2), o})
    `CHK({mw_bypass_off_r, relaxed_order_off_r, port_disabled_r}, {t[5], t[6], t[10]})
    `CHK({rate_change_attempt_count_r, reset_select_r}, {t[9:8], t[11] & upstream_role})
    `CHK({phy_control_byte_r, retrain_on_error_off_r}, {t[23:16], t[16]})
    `CHK({lane_mode_r, phy_delta_r, operating_mode_r}, {p[6:0], p[31:15], o[15:0]})
    `CHK(reference_clock_output_pair_en_r, o[23] ? 7'h00 : o[22:16])
  endtask
  task rst();
    nrst = 1'b0;
    repeat (16) @(negedge clk);
    m = '{`SPCFG_TL_RST, `SPCFG_PL_RST, `SPCFG_PM_RST, (`SPCFG_OM_RST & 32'hFF00FFFF)
      | {8'h00, clock_buffer_powerdown_strap, six_port_package ? 7'h7F : 7'h5F, 16'h0000}};
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    check();
  endtask
  // Random same-cycle traffic on all three write paths plus a read
  task op();
    @(negedge clk);
    r = rnd();
    cfg_addr = 8'h8C + {r[2:0], 2'b00};
    sb_addr = 8'h8C + {r[4:3], 2'b00};
    ee_addr = 8'h8C + {r[6:5], 2'b00};
    {cfg_be, sb_be, ee_be, cfg_rd, cfg_wr, ee_wr, sb_wr} = r[22:7];
    cfg_wdata = rnd();
    sb_wdata = rnd();
    ee_wdata = rnd();
    v = cfg_rd;
    rexp = r[2] ? 32'h0 : eff(r[1:0]);
    if (cfg_wr) wr(cfg_addr, cfg_wdata, cfg_be, 0);
    if (ee_wr) wr(ee_addr, ee_wdata, ee_be, 1);
    if (sb_wr) wr(sb_addr, sb_wdata, sb_be, 2);
    @(negedge clk);
    {cfg_rd, cfg_wr, ee_wr, sb_wr} = 4'h0;
    `CHK(cfg_rvalid_r, v)
    if (v) `CHK(cfg_rdata_r, rexp)
    @(negedge clk);
    check();
  endtask
  task finish_test();
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    own = '{`SPCFG_TL_UPOWN, `SPCFG_PL_UPOWN, `SPCFG_PM_UPOWN, `SPCFG_OM_UPOWN};
    imp = '{`SPCFG_TL_IMPL, `SPCFG_PL_IMPL, `SPCFG_PM_IMPL, `SPCFG_OM_IMPL};
    upw = '{32'h0, 32'h0, 32'h0, 32'h0};
    rst();
    repeat (150) op();
    upw = '{rnd(), rnd(), rnd(), rnd()};
    upstream_role = 1'b0;
    repeat (4) @(negedge clk);
    check();
    repeat (150) op();
    clock_buffer_powerdown_strap = 1'b1;
    six_port_package = 1'b1;
    upstream_role = 1'b1;
    rst();
    repeat (50) op();
    finish_test();
  end
endmodule
bind spcfg_regs spcfg_regs_checker spcfg_regs_checker_inst (
  .clk (clk), .nrst (nrst), .clock_buffer_powerdown_strap (clock_buffer_powerdown_strap),
  .upstream_role (upstream_role), .cfg_rd (cfg_rd), .cfg_wr (cfg_wr), .cfg_addr (cfg_addr),
  .cfg_wdata (cfg_wdata), .cfg_be (cfg_be), .ee_wr (ee_wr), .sb_wr (sb_wr), .sb_addr (sb_addr),
  .sb_wdata (sb_wdata), .sb_be (sb_be), .cfg_rdata_r (cfg_rdata_r), .cfg_rvalid_r (cfg_rvalid_r),
  .tl_word_r (tl_word_r), .om_word_r (om_word_r), .port_disabled_r (port_disabled_r),
  .relaxed_order_off_r (relaxed_order_off_r), .reset_select_r (reset_select_r),
  .phy_control_byte_r (phy_control_byte_r), .retrain_on_error_off_r (retrain_on_error_off_r),
  .lane_mode_r (lane_mode_r), .phy_delta_r (phy_delta_r), .operating_mode_r (operating_mode_r),
  .reference_clock_output_pair_en_r (reference_clock_output_pair_en_r)
);
